// ==== include/pms_pkg.sv ====
// Package of constants and types for the power-manager serial slave and mode machine
package pms_pkg;
    // Fixed 7-bit bus address of the slave
    localparam logic [6:0] PMS_SLAVE_ADDR = 7'h60;
    // Register file geometry
    localparam int PMS_REG_AW = 8;
    localparam int PMS_REG_DW = 8;
    localparam int PMS_NUM_REGS = 256;
    // Number of one-time-programmable words copied at power-up
    localparam logic [7:0] PMS_OTP_WORDS = 8'h16;
    // Reset values and bits per byte
    localparam logic [7:0] PMS_INDEX_RST = 8'h00;
    localparam logic [3:0] PMS_BITCNT_RST = 4'h0;
    localparam logic [3:0] PMS_BITS_PER_BYTE = 4'h8;
    // Undervoltage rising filter, 3 us at 125 MHz (8 ns)
    localparam int PMS_CLK_PERIOD_NS = 8;
    localparam int PMS_UV_RISE_NS = 3000;
    localparam int PMS_UV_RISE_CYC = (PMS_UV_RISE_NS + PMS_CLK_PERIOD_NS - 1) / PMS_CLK_PERIOD_NS;
    localparam logic [9:0] PMS_UV_RISE_CNT = 10'(PMS_UV_RISE_CYC);

    // Operating modes
    typedef enum logic [1:0] {
        PMS_SHUTDOWN,
        PMS_OTP_LOAD,
        PMS_STANDBY,
        PMS_ACTIVE
    } pms_mode_e;

    // Serial slave states
    typedef enum logic [2:0] {
        PMS_IDLE,
        PMS_ADDR,
        PMS_ADDR_ACK,
        PMS_RX,
        PMS_RX_ACK,
        PMS_TX,
        PMS_TX_ACK
    } pms_i2c_e;
endpackage : pms_pkg

// ==== rtl/pms_regmem.sv ====
// Register file memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module pms_regmem
    import pms_pkg::*;
(
    input wire logic mclk,
    input wire logic we,
    input wire logic [PMS_REG_AW-1:0] waddr,
    input wire logic [PMS_REG_DW-1:0] wdata,
    input wire logic [PMS_REG_AW-1:0] raddr,
    output logic [PMS_REG_DW-1:0] rdata
);
    logic [PMS_REG_DW-1:0] mem [PMS_NUM_REGS];

    // Contents are not reset; OTP load fills the used words
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : pms_regmem
`default_nettype wire

// ==== rtl/pms_sync.sv ====
// Two-flop synchroniser for levels entering the mclk domain
`timescale 1ns/1ps
`default_nettype none
module pms_sync
    import pms_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic din,
    input wire logic rst_val,
    output logic dout
);
    logic meta_r;
    logic meta_nxt;
    logic dout_nxt;

    // Next values: first stage feeds only the second
    always_comb begin
        meta_nxt = din;
        dout_nxt = meta_r;
    end

    // Reset to the line's idle level so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= rst_val;
            dout <= rst_val;
        end else begin
            meta_r <= meta_nxt;
            dout <= dout_nxt;
        end
    end
endmodule : pms_sync
`default_nettype wire

// ==== rtl/pms_top.sv ====
// Power-manager operating-mode machine and register-access serial slave
`timescale 1ns/1ps
`default_nettype none
module pms_top
    import pms_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic supply_ok,
    input wire logic reg_enable_any,
    input wire logic [PMS_REG_DW-1:0] otp_data,
    output logic [PMS_REG_AW-1:0] otp_addr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic bias_on,
    output logic regs_allowed,
    output logic [1:0] mode,
    output logic bus_busy
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic scl_s;
    logic sda_s;
    logic sup_s;
    logic ena_s;

    pms_sync u_sync_scl (.mclk(mclk), .srst(srst), .din(scl_i), .rst_val(1'b1), .dout(scl_s));
    pms_sync u_sync_sda (.mclk(mclk), .srst(srst), .din(sda_i), .rst_val(1'b1), .dout(sda_s));
    pms_sync u_sync_sup (.mclk(mclk), .srst(srst), .din(~supply_ok), .rst_val(1'b1), .dout(sup_s));
    pms_sync u_sync_ena (.mclk(mclk), .srst(srst), .din(~reg_enable_any), .rst_val(1'b1),
        .dout(ena_s));
    logic supply_good;
    logic en_req;
    assign supply_good = ~sup_s;
    assign en_req = ~ena_s;

    ////////////////////////////////////////////////////////////////////////////
    // Mode machine
    pms_mode_e mode_r, mode_nxt;
    logic [9:0] uv_cnt_r, uv_cnt_nxt;
    logic [PMS_REG_AW-1:0] otp_ptr_r, otp_ptr_nxt;
    logic otp_wr_r, otp_wr_nxt;
    logic [PMS_REG_AW-1:0] otp_waddr_r, otp_waddr_nxt;
    // Supply drop acts at once; the rise is filtered for 3 us
    always_comb begin
        mode_nxt = mode_r;
        uv_cnt_nxt = uv_cnt_r;
        otp_ptr_nxt = otp_ptr_r;
        otp_wr_nxt = 1'b0;
        otp_waddr_nxt = otp_ptr_r;
        if (!supply_good) begin
            mode_nxt = PMS_SHUTDOWN;
            uv_cnt_nxt = '0;
            otp_ptr_nxt = PMS_INDEX_RST;
        end else begin
            unique case (mode_r)
                PMS_SHUTDOWN: begin
                    if (uv_cnt_r == PMS_UV_RISE_CNT) begin
                        mode_nxt = PMS_OTP_LOAD;
                    end else begin
                        uv_cnt_nxt = uv_cnt_r + 10'h001;
                    end
                end
                PMS_OTP_LOAD: begin
                    // One word per cycle; memory read latency handled by delayed write
                    otp_wr_nxt = 1'b1;
                    otp_ptr_nxt = otp_ptr_r + 8'h01;
                    if (otp_ptr_r == PMS_OTP_WORDS - 8'h01) begin
                        mode_nxt = PMS_STANDBY;
                    end
                end
                PMS_STANDBY: begin
                    if (en_req) begin
                        mode_nxt = PMS_ACTIVE;
                    end
                end
                PMS_ACTIVE: begin
                    if (!en_req) begin
                        mode_nxt = PMS_STANDBY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r <= PMS_SHUTDOWN;
            uv_cnt_r <= 10'h000;
            otp_ptr_r <= PMS_INDEX_RST;
            otp_wr_r <= 1'b0;
            otp_waddr_r <= PMS_INDEX_RST;
        end else begin
            mode_r <= mode_nxt;
            uv_cnt_r <= uv_cnt_nxt;
            otp_ptr_r <= otp_ptr_nxt;
            otp_wr_r <= otp_wr_nxt;
            otp_waddr_r <= otp_waddr_nxt;
        end
    end

    // Serial access only once registers hold their loaded values
    logic access_ok;
    assign access_ok = (mode_r == PMS_STANDBY) || (mode_r == PMS_ACTIVE);

    ////////////////////////////////////////////////////////////////////////////
    // Bus event detection on synchronised lines
    logic scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    always_ff @(posedge mclk) begin
        if (srst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end
    // Oversampling at 125 MHz resolves 3.4 MHz SCL with margin
    always_comb begin
        scl_rise = scl_s & ~scl_d_r;
        scl_fall = ~scl_s & scl_d_r;
        start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
        stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave
    pms_i2c_e st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [PMS_REG_AW-1:0] idx_r, idx_nxt;
    logic have_idx_r, have_idx_nxt;
    logic busy_r, busy_nxt;
    logic sda_r, sda_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] wdat_r, wdat_nxt;
    logic [PMS_REG_AW-1:0] widx_r, widx_nxt;
    logic [PMS_REG_DW-1:0] rdata;
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        idx_nxt = idx_r;
        have_idx_nxt = have_idx_r;
        busy_nxt = busy_r;
        sda_nxt = sda_r;
        wr_nxt = 1'b0;
        wdat_nxt = wdat_r;
        widx_nxt = widx_r;
        if (start_ev) begin
            // Repeated START restarts address phase, index is kept
            busy_nxt = 1'b1;
            st_nxt = PMS_ADDR;
            bit_nxt = PMS_BITCNT_RST;
            have_idx_nxt = 1'b0;
            sda_nxt = 1'b0;
        end else if (stop_ev) begin
            busy_nxt = 1'b0;
            st_nxt = PMS_IDLE;
            sda_nxt = 1'b0;
        end else if (scl_rise) begin
            // Sample on SCL rise, data is stable while high
            unique case (st_r)
                PMS_ADDR, PMS_RX: begin
                    sh_nxt = {sh_r[6:0], sda_s};
                    bit_nxt = bit_r + 4'h1;
                end
                PMS_TX_ACK: begin
                    if (sda_s) begin
                        st_nxt = PMS_IDLE;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            // Drive only after SCL falls so SDA never moves while high
            unique case (st_r)
                PMS_ADDR: begin
                    if (bit_r == PMS_BITS_PER_BYTE) begin
                        if (sh_r[7:1] == PMS_SLAVE_ADDR && access_ok) begin
                            st_nxt = PMS_ADDR_ACK;
                            sda_nxt = 1'b1;
                        end else begin
                            st_nxt = PMS_IDLE;
                        end
                    end
                end
                PMS_ADDR_ACK: begin
                    bit_nxt = PMS_BITCNT_RST;
                    if (sh_r[0]) begin
                        st_nxt = PMS_TX;
                        sh_nxt = rdata;
                        sda_nxt = ~rdata[7];
                        bit_nxt = 4'h1;
                    end else begin
                        st_nxt = PMS_RX;
                        sda_nxt = 1'b0;
                    end
                end
                PMS_RX: begin
                    if (bit_r == PMS_BITS_PER_BYTE) begin
                        st_nxt = PMS_RX_ACK;
                        sda_nxt = 1'b1;
                        if (!have_idx_r) begin
                            idx_nxt = sh_r;
                            have_idx_nxt = 1'b1;
                        end else begin
                            wr_nxt = 1'b1;
                            wdat_nxt = sh_r;
                            widx_nxt = idx_r;
                            idx_nxt = idx_r + 8'h01;
                        end
                    end
                end
                PMS_RX_ACK: begin
                    st_nxt = PMS_RX;
                    bit_nxt = PMS_BITCNT_RST;
                    sda_nxt = 1'b0;
                end
                PMS_TX: begin
                    if (bit_r == PMS_BITS_PER_BYTE) begin
                        st_nxt = PMS_TX_ACK;
                        sda_nxt = 1'b0;
                    end else begin
                        sda_nxt = ~sh_r[3'(7 - bit_r)];
                        bit_nxt = bit_r + 4'h1;
                    end
                end
                PMS_TX_ACK: begin
                    // ACK again: resend the same register, no increment
                    st_nxt = PMS_TX;
                    sh_nxt = rdata;
                    sda_nxt = ~rdata[7];
                    bit_nxt = 4'h1;
                end
                default: ;
            endcase
        end
        if (!supply_good) begin
            st_nxt = PMS_IDLE;
            sda_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= PMS_IDLE;
            bit_r <= PMS_BITCNT_RST;
            sh_r <= 8'h00;
            idx_r <= PMS_INDEX_RST;
            have_idx_r <= 1'b0;
            busy_r <= 1'b0;
            sda_r <= 1'b0;
            wr_r <= 1'b0;
            wdat_r <= 8'h00;
            widx_r <= PMS_INDEX_RST;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            idx_r <= idx_nxt;
            have_idx_r <= have_idx_nxt;
            busy_r <= busy_nxt;
            sda_r <= sda_nxt;
            wr_r <= wr_nxt;
            wdat_r <= wdat_nxt;
            widx_r <= widx_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register memory: OTP load owns the write port outside access modes
    logic mem_we;
    logic [PMS_REG_AW-1:0] mem_waddr;
    logic [PMS_REG_DW-1:0] mem_wdata;
    assign mem_we = otp_wr_r | (wr_r & access_ok);
    assign mem_waddr = otp_wr_r ? otp_waddr_r : widx_r;
    assign mem_wdata = otp_wr_r ? otp_data : wdat_r;
    pms_regmem u_mem (
        .mclk(mclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(idx_r),
        .rdata(rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            sda_oe_n <= 1'b1;
            bias_on <= 1'b0;
            regs_allowed <= 1'b0;
            mode <= 2'h0;
            bus_busy <= 1'b0;
            otp_addr <= PMS_INDEX_RST;
            sda_o <= 1'b0;
        end else begin
            sda_oe_n <= ~(sda_nxt & supply_good);
            bias_on <= (mode_nxt != PMS_SHUTDOWN);
            regs_allowed <= (mode_nxt == PMS_ACTIVE);
            mode <= mode_nxt;
            bus_busy <= busy_nxt;
            otp_addr <= otp_waddr_nxt; // Same word as the write next cycle
            sda_o <= 1'b0; // Open drain: only ever pulls low
        end
    end
endmodule : pms_top
`default_nettype wire

// ==== test/pms_bus_master.sv ====
// Behavioural bus master on the open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module pms_bus_master (
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda
);
    logic scl_r = 1'b1;
    logic sdo_r = 1'b1;
    // Pull-ups: a released line reads high, clock stands still between frames
    assign scl = scl_r;
    assign sda = sdo_r & sda_oe_n;
    // Quarter of the 125 ns bus period
    task automatic q;
        #31.25;
    endtask : q
    // Also serves as repeated start when entered with the clock low
    task automatic start;
        sdo_r = 1'b1;
        q();
        scl_r = 1'b1;
        q();
        sdo_r = 1'b0;
        q();
        scl_r = 1'b0;
        q();
    endtask : start
    task automatic stop;
        sdo_r = 1'b0;
        q();
        scl_r = 1'b1;
        q();
        sdo_r = 1'b1;
        q();
    endtask : stop
    // Data set only in the low half, sampled mid high
    task automatic bitx(input logic b, output logic r);
        sdo_r = b;
        q();
        scl_r = 1'b1;
        q();
        r = sda;
        q();
        scl_r = 1'b0;
        q();
    endtask : bitx
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(nack, r);
    endtask : rbyte
endmodule : pms_bus_master
`default_nettype wire

// ==== test/pms_top_properties.sv ====
// Checker of mode machine and serial slave port relations
`timescale 1ns/1ps
`default_nettype none
module pms_top_properties
    import pms_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic supply_ok,
    input wire logic reg_enable_any,
    input wire logic [PMS_REG_DW-1:0] otp_data,
    input wire logic [PMS_REG_AW-1:0] otp_addr,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic bias_on,
    input wire logic regs_allowed,
    input wire logic [1:0] mode,
    input wire logic bus_busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    // Eight cycles covers the sync flops plus the mode update
    shut_mode_a: assert property (!supply_ok [*8] |-> mode == 2'h0 && !bias_on)
        else $error("mode not shutdown under low supply");
    uv_quiet_a: assert property (!supply_ok [*8] |-> sda_oe_n)
        else $error("data line driven under low supply");
    otp_off_a: assert property (mode == 2'h1 |-> !regs_allowed && otp_addr <= PMS_OTP_WORDS)
        else $error("regulators or index wrong in otp load");
    stby_off_a: assert property (mode == 2'h2 && $past(mode) == 2'h2 |-> !regs_allowed && bias_on)
        else $error("regulators on in standby");
    active_run_a: assert property (mode == 2'h3 && $past(mode) == 2'h3 |-> regs_allowed)
        else $error("regulators off in active");
    enable_wake_a: assert property ((supply_ok && reg_enable_any && mode == 2'h2) [*2]
        |-> ##[0:4] mode == 2'h3)
        else $error("enable did not leave standby");
    // Pin edges are raw here; the master holds each level for four cycles
    start_busy_a: assert property ($fell(sda_i) && scl_i && $past(scl_i) && mode[1]
        |-> ##[1:8] bus_busy)
        else $error("start not seen");
    stop_free_a: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:8] !bus_busy)
        else $error("stop not seen");
    sda_low_scl_a: assert property ($changed(sda_oe_n) && supply_ok |-> !scl_i)
        else $error("data changed while clock high");
    cover property (mode == 2'h3);
    cover property (!sda_oe_n && mode == 2'h3);
    cover property ($fell(bus_busy));
endmodule : pms_top_properties
bind pms_top pms_top_properties u_props (.mclk(mclk), .srst(srst), .supply_ok(supply_ok),
    .reg_enable_any(reg_enable_any), .otp_data(otp_data), .otp_addr(otp_addr),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .bias_on(bias_on),
    .regs_allowed(regs_allowed), .mode(mode), .bus_busy(bus_busy));
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the mode machine and serial slave
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pms_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic supply_ok = 1'b0;
    logic reg_enable_any = 1'b0;
    logic [7:0] otp_data;
    logic [7:0] otp_addr;
    logic scl, sda, sda_o, sda_oe_n, bias_on, regs_allowed, bus_busy;
    logic [1:0] mode;
    int mismatches = 0;
    int check_count = 0;
    // OTP words are a fixed pattern of their index
    assign otp_data = otp_addr ^ 8'hA5;
    pms_top DUT (.mclk(mclk), .srst(srst), .supply_ok(supply_ok),
        .reg_enable_any(reg_enable_any), .otp_data(otp_data), .otp_addr(otp_addr),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .bias_on(bias_on),
        .regs_allowed(regs_allowed), .mode(mode), .bus_busy(bus_busy));
    pms_bus_master m (.sda_oe_n(sda_oe_n | sda_o), .scl(scl), .sda(sda));
    initial begin
        forever #4 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // Bounded wait, so a stuck machine fails instead of hanging
    task automatic wait_mode(input logic [1:0] md, input int lim);
        int n;
        n = 0;
        while (mode !== md && n < lim) begin
            cyc(1);
            n++;
        end
        chk(mode === md, "mode not reached");
    endtask : wait_mode
    task automatic wr3(input logic [7:0] idx, input logic [23:0] d);
        logic a;
        m.start();
        m.wbyte({PMS_SLAVE_ADDR, 1'b0}, a);
        chk(a, "no ack on address");
        m.wbyte(idx, a);
        chk(a, "no ack on index");
        for (int i = 2; i >= 0; i--) begin
            m.wbyte(d[i*8 +: 8], a);
            chk(a, "no ack on data");
        end
        chk(bus_busy === 1'b1, "bus not busy");
        m.stop();
    endtask : wr3
    task automatic rd2(input logic [7:0] idx, input logic [7:0] exp);
        logic a;
        logic [7:0] b0, b1;
        m.start();
        m.wbyte({PMS_SLAVE_ADDR, 1'b0}, a);
        m.wbyte(idx, a);
        m.start();
        m.wbyte({PMS_SLAVE_ADDR, 1'b1}, a);
        chk(a, "no ack on read address");
        m.rbyte(1'b0, b0);
        m.rbyte(1'b1, b1);
        m.stop();
        chk(b0 === exp, "read data");
        chk(b1 === exp, "read advanced");
    endtask : rd2
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(mode === 2'h0 && bias_on === 1'b0 && sda_oe_n === 1'b1, "reset state");
        $display("t_reset done");
    endtask : t_reset
    // Filter, OTP copy, standby; last OTP word is the boundary
    task automatic t_powerup;
        supply_ok = 1'b1;
        wait_mode(2'h1, 500);
        chk(regs_allowed === 1'b0, "regulators on in load");
        wait_mode(2'h2, 200);
        chk(bias_on === 1'b1 && regs_allowed === 1'b0, "standby outputs");
        rd2(8'h03, 8'hA6);
        rd2(8'h15, 8'hB0);
        $display("t_powerup done");
    endtask : t_powerup
    task automatic t_write;
        wr3(8'h40, 24'h112233);
        rd2(8'h40, 8'h11);
        rd2(8'h41, 8'h22);
        rd2(8'h42, 8'h33);
        $display("t_write done");
    endtask : t_write
    // A neighbour address must neither be acknowledged nor stored
    task automatic t_wrong;
        logic a;
        m.start();
        m.wbyte(8'hC2, a);
        chk(!a, "foreign address acked");
        m.wbyte(8'h41, a);
        m.wbyte(8'h77, a);
        m.stop();
        rd2(8'h41, 8'h22);
        $display("t_wrong done");
    endtask : t_wrong
    task automatic t_active;
        cyc(1);
        reg_enable_any = 1'b1;
        wait_mode(2'h3, 50);
        chk(regs_allowed === 1'b1, "regulators off in active");
        wr3(8'h50, 24'hA1B2C3);
        rd2(8'h52, 8'hC3);
        cyc(1);
        reg_enable_any = 1'b0;
        wait_mode(2'h2, 50);
        $display("t_active done");
    endtask : t_active
    // Supply lost mid-transfer: shutdown, silence, recovery to standby
    task automatic t_uv;
        logic a;
        m.start();
        m.wbyte({PMS_SLAVE_ADDR, 1'b0}, a);
        cyc(1);
        supply_ok = 1'b0;
        wait_mode(2'h0, 10);
        m.wbyte(8'h60, a);
        chk(!a, "acked under low supply");
        m.stop();
        cyc(1);
        supply_ok = 1'b1;
        wait_mode(2'h2, 1000);
        $display("t_uv done");
    endtask : t_uv
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence after five reset cycles
    initial begin
        cyc(5);
        srst = 1'b0;
        t_reset();
        t_powerup();
        t_write();
        t_wrong();
        t_active();
        t_uv();
        report_and_stop();
    end
    // Watchdog at several times the expected run of about 66 us
    initial begin
        #600us;
        mismatches++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
